// ==== common/rcam_pkg.sv ====
// Package for the regulator configuration and analog mux register bank
package rcam_pkg;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned NUM_REGS = 6;

	// Bit index of each regulator in the per-regulator vectors
	localparam int unsigned REG_BOOSTER = 5;
	localparam int unsigned REG_STEPDOWN_HI = 4;
	localparam int unsigned REG_STEPDOWN_LO = 2;
	localparam int unsigned REG_LINEAR_ONE = 1;
	localparam int unsigned REG_LINEAR_TWO = 0;

	// Register select codes on the register access port
	localparam logic SEL_REG_CONFIG = 1'b0;
	localparam logic SEL_ANALOG_MUX = 1'b1;

	// Field positions within the 16-bit register word
	// (word bit 15 carries frame bit 23, word bit 0 carries frame bit 8)
	localparam int unsigned BOOST_SLEW_HI = 15;
	localparam int unsigned BOOST_SLEW_LO = 14;
	localparam int unsigned ACTION_HI = 13;
	localparam int unsigned ACTION_LO = 8;
	localparam int unsigned LOWSIDE_HI = 4;
	localparam int unsigned LOWSIDE_LO = 3;
	localparam int unsigned HIGHSIDE_HI = 1;
	localparam int unsigned HIGHSIDE_LO = 0;
	localparam int unsigned RATIO_BIT = 5;
	localparam int unsigned CHANNEL_HI = 4;
	localparam int unsigned CHANNEL_LO = 0;

	// Bits that hold storage; all other positions read as zero
	localparam logic [15:0] CONFIG_MASK = 16'hFF1B;
	localparam logic [15:0] ANALOG_MUX_MASK = 16'h003F;

	// Fixed reset values
	localparam logic [1:0] LOWSIDE_RESET = 2'h3;
	localparam logic ZERO_BIT = 1'b0;
	localparam logic [1:0] ZERO_2 = 2'h0;
	localparam logic [4:0] ZERO_5 = 5'h00;
	localparam logic [5:0] ZERO_6 = 6'h00;
	localparam logic [15:0] ZERO_WORD = 16'h0000;

	// Regulator order in all per-regulator vectors:
	// 5 booster, 4..2 step-down one..three, 1 linear one, 0 linear two
	typedef struct packed {
		logic [1:0] booster_slew_select;
		logic [5:0] overtemp_action;
		logic [1:0] prereg_highside_drive;
	} rcam_otp_t;

	typedef struct packed {
		logic [1:0] booster_slew_select;
		logic [5:0] overtemp_action;
		logic [1:0] prereg_lowside_drive;
		logic [1:0] prereg_highside_drive;
	} rcam_config_t;

	typedef struct packed {
		logic divider_ratio;
		logic [4:0] analog_channel_select;
	} rcam_analog_channel_select_t;
endpackage

// ==== src/rcam_regs.sv ====
// Regulator slew, thermal shutdown action and analog mux register bank
`timescale 1ns/1ps

// Summary of operation
// - Two-bit booster slew field: 00 slowest through 11 fastest.
// - Booster overtemp bit: 0 shuts booster only, 1 adds deep failsafe.
// - Each step-down regulator has its own overtemp action bit, same meaning.
// - Linear one overtemp action bit: 0 shutdown only, 1 adds deep failsafe.
// - Linear two overtemp action bit: 0 shutdown only, 1 adds deep failsafe.
// - Pre-regulator low-side drive field, two bits, resets to binary 11.
// - Pre-regulator high-side drive field, two bits, four drive strengths.
// - Mux divider ratio bit selects the low or high input attenuation.
module rcam_regs
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire rcam_pkg::rcam_otp_t otp_defaults_in,
	input wire logic reg_sel_in,
	input wire logic wr_en_in,
	input wire logic [15:0] wr_data_in,
	input wire logic rd_en_in,
	input wire logic [rcam_pkg::NUM_REGS-1:0] thermal_shutdown_in,
	output rcam_pkg::rcam_config_t config_out,
	output rcam_pkg::rcam_analog_channel_select_t analog_channel_select_out,
	output logic [15:0] rd_data_out,
	output logic [rcam_pkg::NUM_REGS-1:0] regulator_shutdown_out,
	output logic deep_failsafe_state_req_out
);
	// Stored register contents; word bit k carries frame bit k + 8
	rcam_pkg::rcam_config_t config_q;
	rcam_pkg::rcam_config_t config_d;
	rcam_pkg::rcam_analog_channel_select_t analog_channel_select_q;
	rcam_pkg::rcam_analog_channel_select_t analog_channel_select_d;

	// Read holding register and the two assembled read words
	logic [15:0] rd_data_q;
	logic [15:0] rd_data_d;
	logic [15:0] cfg_rd;
	logic [15:0] mux_rd;

	// Overtemperature path
	logic [rcam_pkg::NUM_REGS-1:0] shutdown_q;
	logic [rcam_pkg::NUM_REGS-1:0] escalate;
	logic failsafe_q;
	logic failsafe_d;

	// Access decode; a read and a write may share one edge
	wire sel_config = (reg_sel_in == rcam_pkg::SEL_REG_CONFIG);
	wire sel_analog_channel_select = (reg_sel_in == rcam_pkg::SEL_ANALOG_MUX);
	wire wr_config = wr_en_in && sel_config;
	wire wr_analog_channel_select = wr_en_in && sel_analog_channel_select;
	wire rd_config = rd_en_in && sel_config;
	wire rd_analog_channel_select = rd_en_in && sel_analog_channel_select;

	// Reserved bits are dropped on write so a careless host cannot set them
	// No error is flagged for them; they simply read back as zero
	wire [15:0] cfg_wr = wr_data_in & rcam_pkg::CONFIG_MASK;
	wire [15:0] mux_wr = wr_data_in & rcam_pkg::ANALOG_MUX_MASK;

	// Field slices of the incoming word
	wire [1:0] wr_slew =
		cfg_wr[rcam_pkg::BOOST_SLEW_HI:rcam_pkg::BOOST_SLEW_LO];
	wire [5:0] wr_action =
		cfg_wr[rcam_pkg::ACTION_HI:rcam_pkg::ACTION_LO];
	wire [1:0] wr_lowside =
		cfg_wr[rcam_pkg::LOWSIDE_HI:rcam_pkg::LOWSIDE_LO];
	wire [1:0] wr_highside =
		cfg_wr[rcam_pkg::HIGHSIDE_HI:rcam_pkg::HIGHSIDE_LO];
	wire wr_ratio = mux_wr[rcam_pkg::RATIO_BIT];
	wire [4:0] wr_channel =
		mux_wr[rcam_pkg::CHANNEL_HI:rcam_pkg::CHANNEL_LO];

	// Code 10 of the low-side drive has no defined strength; it is kept as
	// written so a read shows exactly what the host sent
	assign config_d = wr_config ? rcam_pkg::rcam_config_t'{
		booster_slew_select: wr_slew,
		overtemp_action: wr_action,
		prereg_lowside_drive: wr_lowside,
		prereg_highside_drive: wr_highside
	} : config_q;

	// Channel and ratio keep their code until the next mux write
	assign analog_channel_select_d = wr_analog_channel_select ? rcam_pkg::rcam_analog_channel_select_t'{
		divider_ratio: wr_ratio,
		analog_channel_select: wr_channel
	} : analog_channel_select_q;

	// Readback assembles fields in place; every other bit is zero
	always_comb
	begin
		cfg_rd = rcam_pkg::ZERO_WORD;
		cfg_rd[rcam_pkg::BOOST_SLEW_HI:rcam_pkg::BOOST_SLEW_LO] =
			config_q.booster_slew_select;
		cfg_rd[rcam_pkg::ACTION_HI:rcam_pkg::ACTION_LO] =
			config_q.overtemp_action;
		cfg_rd[rcam_pkg::LOWSIDE_HI:rcam_pkg::LOWSIDE_LO] =
			config_q.prereg_lowside_drive;
		cfg_rd[rcam_pkg::HIGHSIDE_HI:rcam_pkg::HIGHSIDE_LO] =
			config_q.prereg_highside_drive;
	end

	always_comb
	begin
		mux_rd = rcam_pkg::ZERO_WORD;
		mux_rd[rcam_pkg::RATIO_BIT] = analog_channel_select_q.divider_ratio;
		mux_rd[rcam_pkg::CHANNEL_HI:rcam_pkg::CHANNEL_LO] =
			analog_channel_select_q.analog_channel_select;
	end

	// Reads take the stored contents, so a write on the same edge is
	// seen only by the next read
	assign rd_data_d = rd_config ? cfg_rd :
		rd_analog_channel_select ? mux_rd : rd_data_q;

	// Per regulator: overtemp always shuts it down, escalation only if chosen
	genvar g;
	generate
		for (g = 0; g < rcam_pkg::NUM_REGS; g++)
		begin : g_reg
			assign escalate[g] = thermal_shutdown_in[g] &&
				config_q.overtemp_action[g];
		end
	endgenerate

	// Named escalation sources, one per regulator group
	wire esc_booster = escalate[rcam_pkg::REG_BOOSTER];
	wire esc_stepdown = |escalate[rcam_pkg::REG_STEPDOWN_HI:
		rcam_pkg::REG_STEPDOWN_LO];
	wire esc_linear_one = escalate[rcam_pkg::REG_LINEAR_ONE];
	wire esc_linear_two = escalate[rcam_pkg::REG_LINEAR_TWO];

	// The request is a level: it drops one cycle after the last cause
	// clears, so the main state machine has to latch it on its own side
	assign failsafe_d = esc_booster || esc_stepdown ||
		esc_linear_one || esc_linear_two;

	// Sync reset acts even with the clock enable low; OTP defaults are
	// sampled only here, so a later change on those pins has no effect
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			config_q.booster_slew_select <=
				otp_defaults_in.booster_slew_select;
			config_q.overtemp_action <= otp_defaults_in.overtemp_action;
			config_q.prereg_lowside_drive <= rcam_pkg::LOWSIDE_RESET;
			config_q.prereg_highside_drive <=
				otp_defaults_in.prereg_highside_drive;
		end
		else if (ce_in)
		begin
			config_q <= config_d;
		end
	end

	// Mux register has fixed zero reset values
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			analog_channel_select_q.divider_ratio <= rcam_pkg::ZERO_BIT;
			analog_channel_select_q.analog_channel_select <= rcam_pkg::ZERO_5;
		end
		else if (ce_in)
		begin
			analog_channel_select_q <= analog_channel_select_d;
		end
	end

	// Read data holds until the next read so the host may fetch it late
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			rd_data_q <= rcam_pkg::ZERO_WORD;
		end
		else if (ce_in)
		begin
			rd_data_q <= rd_data_d;
		end
	end

	// Shutdown follows the overtemp inputs one cycle later, whatever the
	// action bits say
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			shutdown_q <= rcam_pkg::ZERO_6;
		end
		else if (ce_in)
		begin
			shutdown_q <= thermal_shutdown_in;
		end
	end

	// Escalation request freezes with the clock enable like all other state
	always_ff @(posedge core_clk_in)
	begin
		if (rst_in)
		begin
			failsafe_q <= rcam_pkg::ZERO_BIT;
		end
		else if (ce_in)
		begin
			failsafe_q <= failsafe_d;
		end
	end

	// Every output comes straight from its flip-flop
	assign config_out = config_q;
	assign analog_channel_select_out = analog_channel_select_q;
	assign rd_data_out = rd_data_q;
	assign regulator_shutdown_out = shutdown_q;
	assign deep_failsafe_state_req_out = failsafe_q;
endmodule

// ==== sim/rcam_regs_asserts.sv ====
// Checker for the regulator config and mux register bank
`timescale 1ns/1ps
module rcam_regs_asserts
(
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic reg_sel_in,
	input wire logic wr_en_in,
	input wire logic rd_en_in,
	input wire logic [15:0] wr_data_in,
	input wire logic [5:0] thermal_shutdown_in,
	input wire rcam_pkg::rcam_config_t config_out,
	input wire rcam_pkg::rcam_analog_channel_select_t analog_channel_select_out,
	input wire logic [15:0] rd_data_out,
	input wire logic deep_failsafe_state_req_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);
	wire wc = ce_in && wr_en_in && !reg_sel_in;
	wire wm = ce_in && wr_en_in && reg_sel_in;
	a_slew_write: assert property (wc |=>
		config_out[11:10] == $past(wr_data_in[15:14])) else $error("slew lost");
	a_boost_failsafe: assert property (ce_in && thermal_shutdown_in[5] &&
		config_out[9] |=> deep_failsafe_state_req_out) else $error("no failsafe");
	a_stepdown_act: assert property (wc |=>
		config_out[8:6] == $past(wr_data_in[12:10])) else $error("action lost");
	a_lowside_write: assert property (wc |=>
		config_out[3:2] == $past(wr_data_in[4:3])) else $error("lowside lost");
	a_highside_write: assert property (wc |=>
		config_out[1:0] == $past(wr_data_in[1:0])) else $error("highside lost");
	a_ratio_write: assert property (wm |=>
		analog_channel_select_out[5] == $past(wr_data_in[5])) else $error("ratio lost");
	a_reserved_zero: assert property (ce_in && rd_en_in |=> (rd_data_out &
		~($past(reg_sel_in) ? 16'h003F : 16'hFF1B)) == 16'h0000)
		else $error("reserved bit set");
	a_channel_hold: assert property (!wm |=> $stable(analog_channel_select_out[4:0]))
		else $error("channel changed");
	cover property (wm);
	cover property (deep_failsafe_state_req_out);
	cover property (ce_in && rd_en_in);
endmodule
bind rcam_regs rcam_regs_asserts i_rcam_regs_asserts (.*);

// ==== sim/rcam_host.sv ====
// Host model driving the register access port
`timescale 1ns/1ps
module rcam_host
(
	input wire logic clk_in,
	output logic sel_out, wr_out, rd_out,
	output logic [15:0] data_out
);
	initial {sel_out, wr_out, rd_out, data_out} = '0;
	// One access per edge; idle data is inverted so stale words never match
	task acc(input logic s, w, r, input logic [15:0] d);
		sel_out <= s;
		wr_out <= w;
		rd_out <= r;
		data_out <= w ? d : ~d;
		@(posedge clk_in);
	endtask
endmodule

// ==== sim/rcam_regs_bench.sv ====
// Self-checking bench for the regulator config and mux register bank
`timescale 1ns/1ps
module rcam_regs_bench;
	logic clk = 0, rst = 1, rd_seen = 0, ce = 1;
	logic [5:0] thermal_shutdown = 6'h00;
	logic [15:0] v = 16'h3420, q[$];
	rcam_pkg::rcam_otp_t otp;
	int errors = 0, checks_done = 0;
	wire logic sel, wr, rd, fs;
	wire logic [15:0] dat, rdata;
	wire logic [5:0] shut;
	always #4 clk = ~clk;
	rcam_host i_rcam_host (.clk_in(clk), .sel_out(sel), .wr_out(wr),
		.rd_out(rd), .data_out(dat));
	rcam_regs i_rcam_regs (.core_clk_in(clk), .rst_in(rst), .ce_in(ce),
		.otp_defaults_in(otp), .reg_sel_in(sel), .wr_en_in(wr),
		.wr_data_in(dat), .rd_en_in(rd), .thermal_shutdown_in(thermal_shutdown),
		.config_out(), .analog_channel_select_out(), .rd_data_out(rdata),
		.regulator_shutdown_out(shut), .deep_failsafe_state_req_out(fs));
	function logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	task check(input string n, input logic [15:0] seen, exp);
		checks_done++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask
	task test_done();
		$display("checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task rdq(input logic s, input logic [15:0] e);
		q.push_back(e);
		i_rcam_host.acc(s, 1'b0, 1'b1, e);
	endtask
	always @(posedge clk)
	begin
		if (rd_seen)
			check("rd_data_out", rdata, q.pop_front());
		rd_seen = rd & !rst & ce;
	end
	initial
	begin
		#100000;
		errors++;
		test_done();
	end
	initial
	begin
		v = nx(v);
		otp = v[9:0];
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		rdq(1'b0, {otp[9:2], 3'h0, 2'h3, 1'h0, otp[1:0]});
		rdq(1'b1, 16'h0000);
		$display("test reset done");
		i_rcam_host.acc(1'b0, 1'b1, 1'b0, 16'hFFFF);
		i_rcam_host.acc(1'b1, 1'b1, 1'b0, 16'hFFFF);
		rdq(1'b0, 16'hFF1B);
		rdq(1'b1, 16'h003F);
		$display("test reserved done");
		repeat (8)
		begin
			v = nx(v);
			i_rcam_host.acc(1'b0, 1'b1, 1'b0, v & 16'hFF1B);
			i_rcam_host.acc(1'b1, 1'b1, 1'b0, v & 16'h003F);
			rdq(1'b0, v & 16'hFF1B);
			rdq(1'b1, v & 16'h003F);
		end
		$display("test random done");
		ce <= 1'b0;
		i_rcam_host.acc(1'b1, 1'b1, 1'b0, ~v & 16'h003F);
		ce <= 1'b1;
		rdq(1'b1, v & 16'h003F);
		$display("test enable done");
		i_rcam_host.acc(1'b0, 1'b1, 1'b0, 16'h3F00);
		thermal_shutdown <= 6'h20;
		repeat (2) @(posedge clk);
		check("failsafe", {15'h0, fs}, 16'h0001);
		check("shutdown", {10'h0, shut}, 16'h0020);
		i_rcam_host.acc(1'b0, 1'b1, 1'b0, 16'h0000);
		repeat (2) @(posedge clk);
		check("failsafe", {15'h0, fs}, 16'h0000);
		check("shutdown", {10'h0, shut}, 16'h0020);
		$display("test overtemp done");
		v = nx(v);
		i_rcam_host.acc(1'b0, 1'b1, 1'b0, v & 16'h3F00);
		for (int g = 0; g < 6; g++)
		begin
			thermal_shutdown <= 6'h01 << g;
			repeat (2) @(posedge clk);
			check("escalate", {15'h0, fs}, {15'h0, v[8 + g]});
			check("shutdown", {10'h0, shut}, 16'h0001 << g);
		end
		$display("test escalate done");
		test_done();
	end
endmodule
